// file: rtl/adcc_regs.vh
// adcc_regs.vh - register offsets, field positions and timing counts for the
// converter control block. assumes byte offsets are register indices; the
// bus byte address is four times the index.
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// ==========================================================================
// register indices
`define ADCC_IDX_CONTROL_MAIN   8'h00
`define ADCC_IDX_ACCUM_CTRL     8'h01
`define ADCC_IDX_REFCLK_CTRL    8'h02
`define ADCC_IDX_DELAY_CTRL     8'h03
`define ADCC_IDX_WINMODE_CTRL   8'h04
`define ADCC_IDX_SAMPLEN_CTRL   8'h05
`define ADCC_IDX_CHANNEL_SEL    8'h06
`define ADCC_IDX_CONV_CMD       8'h08
`define ADCC_IDX_EVENT_CTRL     8'h09
`define ADCC_IDX_INT_ENABLE     8'h0a
`define ADCC_IDX_INT_FLAGS      8'h0b
`define ADCC_IDX_DEBUG_RUN      8'h0c
`define ADCC_IDX_TEMP_BYTE      8'h0d
`define ADCC_IDX_RESULT_LO      8'h10
`define ADCC_IDX_RESULT_HI      8'h11
`define ADCC_IDX_WINLO_LO       8'h12
`define ADCC_IDX_WINLO_HI       8'h13
`define ADCC_IDX_WINHI_LO       8'h14
`define ADCC_IDX_WINHI_HI       8'h15

// ==========================================================================
// field positions
`define ADCC_BIT_ENABLE         0
`define ADCC_BIT_FREE_RUNNING   1
`define ADCC_BIT_RES_SELECT     2
`define ADCC_BIT_RUN_STANDBY    7
`define ADCC_BIT_SAMPLE_CAPACITANCE_SELECT        6
`define ADCC_BIT_FLAG_RESULT_READY_FLAG    0
`define ADCC_BIT_FLAG_WINDOW_COMPARE_FLAG     1

// ==========================================================================
// reset value and write masks
`define ADCC_RESET_BYTE         8'h00
`define ADCC_MASK_CONTROL_MAIN  8'h87
`define ADCC_MASK_ACCUM_CTRL    8'h07
`define ADCC_MASK_REFCLK_CTRL   8'h77
`define ADCC_MASK_WINMODE_CTRL  8'h07
`define ADCC_MASK_SAMPLEN_CTRL  8'h1f
`define ADCC_MASK_CHANNEL_SEL   8'h1f
`define ADCC_MASK_BIT0          8'h01
`define ADCC_MASK_FLAGS         2'h3

// ==========================================================================
// encodings and timing
`define ADCC_ACC_RESERVED       3'h7
`define ADCC_WIN_NONE           3'h0
`define ADCC_WIN_BELOW          3'h1
`define ADCC_WIN_ABOVE          3'h2
`define ADCC_WIN_INSIDE         3'h3
`define ADCC_WIN_OUTSIDE        3'h4
`define ADCC_CONV_ADC_CYCLES    13
`define ADCC_BASE_SAMPLE_CYCLES 2

`endif

// file: rtl/adcc_top.v
// adcc_top.v - register block and conversion sequencer of a 10-bit converter,
// reached as an axi4-lite slave. assumes one clock aclk; the analog core takes
// a start pulse and returns a done pulse with its 10-bit sample on aclk.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "adcc_regs.vh"

// How it works
// - In standby the converter only runs when run_in_standby is set, otherwise it halts.
// - With resolution_select clear, full 10-bit samples are stored or summed.
// - With resolution_select set, the two low bits are dropped before storing or summing.
// - Free-running mode waits for a start_conversion write before its first conversion.
// - In free-running mode each completion sets result_ready_flag and starts the next one.
// - Bit zero of control_main enables the converter.
// - accumulation_count 0 means one sample, 1..6 mean 2..64 samples, 7 is reserved.
// - An accumulation_count of 1..6 sums 2^accumulation_count samples into one result.
// - sample_capacitance_select is driven to the analog core.
// - reference_select 0 picks the internal reference, 1 the supply.
// - The converter clock is the bus clock divided by 2 up to 256 per clock_divider.
// - start_conversion reads one while busy, clears at the end outside free-running mode, and writing zero aborts.
// - window_compare_flag is set by the window_compare_mode test on each final result.
// - With event_start_enable set, a rising event edge starts a conversion.
module adcc_top #(
  parameter SAMPLE_W = 10
) (
  input  wire                aclk,
  input  wire                aresetn,
  input  wire [7:0]          s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output reg                 s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output reg                 s_axi_wready,
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [7:0]          s_axi_araddr,
  input  wire                s_axi_arvalid,
  output reg                 s_axi_arready,
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  input  wire                standby,
  input  wire                start_event,
  output reg                 conv_start,
  input  wire                conv_done,
  input  wire [SAMPLE_W-1:0] conv_sample,
  output reg                 conv_clk,
  output reg                 sample_capacitance_select,
  output reg  [1:0]          reference_select,
  output reg  [4:0]          channel_select,
  output reg                 irq
);

  // ========================================================================
  // registers
  reg  [7:0]  control_main_r;
  reg  [7:0]  accumulation_control_r;
  reg  [7:0]  reference_clock_control_r;
  reg  [7:0]  delay_control_r;
  reg  [7:0]  window_mode_control_r;
  reg  [7:0]  sample_length_control_r;
  reg  [7:0]  input_channel_select_r;
  reg         event_start_enable_r;
  reg  [1:0]  interrupt_enable_r;
  reg  [1:0]  interrupt_flags_r;
  reg         run_while_debug_halted_r;
  reg  [7:0]  temporary_byte_r;
  reg  [15:0] result_r;
  reg  [15:0] low_threshold_r;
  reg  [15:0] high_threshold_r;
  reg  [15:0] accum_r;
  reg  [6:0]  samples_left_r;
  reg         busy_r;
  reg         waiting_r;
  reg  [7:0]  div_cnt_r;
  reg  [2:0]  event_sync_r;
  reg         event_level_r;

  // axi write address and data holding
  reg  [7:0]  aw_addr_r;
  reg         aw_have_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_have_r;

  wire        enable       = control_main_r[`ADCC_BIT_ENABLE];
  wire        free_running = control_main_r[`ADCC_BIT_FREE_RUNNING];
  wire        res_select   = control_main_r[`ADCC_BIT_RES_SELECT];
  wire        run_standby  = control_main_r[`ADCC_BIT_RUN_STANDBY];
  wire [2:0]  accumulation_count  = accumulation_control_r[2:0];
  wire [2:0]  clock_divider       = reference_clock_control_r[2:0];
  wire [2:0]  window_compare_mode = window_mode_control_r[2:0];

  // converter halts in standby unless told to keep running
  wire        may_run = enable & (~standby | run_standby);

  // ========================================================================
  // decode helpers
  // number of samples per complete conversion; reserved code treated as one
  function [6:0] acc_samples;
    input [2:0] code;
    begin
      if (code == `ADCC_ACC_RESERVED)
        acc_samples = 7'h01;
      else
        acc_samples = 7'h01 << code;
    end
  endfunction

  // byte index from an axi byte address; the two low bits are dropped, so misaligned addresses alias
  function [7:0] reg_index;
    input [7:0] addr;
    begin
      reg_index = {2'h0, addr[7:2]};
    end
  endfunction

  // readback of one indexed byte; unmapped and reserved read zero
  function [7:0] read_byte;
    input [7:0] idx;
    begin
      case (idx)
        `ADCC_IDX_CONTROL_MAIN:  read_byte = control_main_r;
        `ADCC_IDX_ACCUM_CTRL:    read_byte = accumulation_control_r;
        `ADCC_IDX_REFCLK_CTRL:   read_byte = reference_clock_control_r;
        `ADCC_IDX_DELAY_CTRL:    read_byte = delay_control_r;
        `ADCC_IDX_WINMODE_CTRL:  read_byte = window_mode_control_r;
        `ADCC_IDX_SAMPLEN_CTRL:  read_byte = sample_length_control_r;
        `ADCC_IDX_CHANNEL_SEL:   read_byte = input_channel_select_r;
        `ADCC_IDX_CONV_CMD:      read_byte = {7'h00, busy_r | waiting_r};
        `ADCC_IDX_EVENT_CTRL:    read_byte = {7'h00, event_start_enable_r};
        `ADCC_IDX_INT_ENABLE:    read_byte = {6'h00, interrupt_enable_r};
        `ADCC_IDX_INT_FLAGS:     read_byte = {6'h00, interrupt_flags_r};
        `ADCC_IDX_DEBUG_RUN:     read_byte = {7'h00, run_while_debug_halted_r};
        `ADCC_IDX_TEMP_BYTE:     read_byte = temporary_byte_r;
        `ADCC_IDX_RESULT_LO:     read_byte = result_r[7:0];
        `ADCC_IDX_RESULT_HI:     read_byte = result_r[15:8];
        `ADCC_IDX_WINLO_LO:      read_byte = low_threshold_r[7:0];
        `ADCC_IDX_WINLO_HI:      read_byte = low_threshold_r[15:8];
        `ADCC_IDX_WINHI_LO:      read_byte = high_threshold_r[7:0];
        `ADCC_IDX_WINHI_HI:      read_byte = high_threshold_r[15:8];
        default:                 read_byte = 8'h00;
      endcase
    end
  endfunction

  // ========================================================================
  // write channel capture: address and data taken in either order
  wire        wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [7:0]  wr_idx  = reg_index(aw_addr_r);
  wire        wr_en   = wr_fire & w_strb_r[0];
  wire [7:0]  wb      = w_data_r[7:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data, always okay
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        s_axi_rdata   <= {24'h000000, read_byte(reg_index(s_axi_araddr))};
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // configuration registers; masks keep reserved bits at zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      control_main_r            <= `ADCC_RESET_BYTE;
      accumulation_control_r    <= `ADCC_RESET_BYTE;
      reference_clock_control_r <= `ADCC_RESET_BYTE;
      delay_control_r           <= `ADCC_RESET_BYTE;
      window_mode_control_r     <= `ADCC_RESET_BYTE;
      sample_length_control_r   <= `ADCC_RESET_BYTE;
      input_channel_select_r    <= `ADCC_RESET_BYTE;
      event_start_enable_r      <= 1'b0;
      interrupt_enable_r        <= 2'h0;
      run_while_debug_halted_r  <= 1'b0;
      temporary_byte_r          <= `ADCC_RESET_BYTE;
      low_threshold_r           <= 16'h0000;
      high_threshold_r          <= 16'h0000;
    end else if (wr_en) begin
      case (wr_idx)
        `ADCC_IDX_CONTROL_MAIN:  control_main_r <= wb & `ADCC_MASK_CONTROL_MAIN;
        `ADCC_IDX_ACCUM_CTRL:    accumulation_control_r <= wb & `ADCC_MASK_ACCUM_CTRL;
        `ADCC_IDX_REFCLK_CTRL:   reference_clock_control_r <= wb & `ADCC_MASK_REFCLK_CTRL;
        `ADCC_IDX_DELAY_CTRL:    delay_control_r <= wb;
        `ADCC_IDX_WINMODE_CTRL:  window_mode_control_r <= wb & `ADCC_MASK_WINMODE_CTRL;
        `ADCC_IDX_SAMPLEN_CTRL:  sample_length_control_r <= wb & `ADCC_MASK_SAMPLEN_CTRL;
        `ADCC_IDX_CHANNEL_SEL:   input_channel_select_r <= wb & `ADCC_MASK_CHANNEL_SEL;
        `ADCC_IDX_EVENT_CTRL:    event_start_enable_r <= wb[0];
        `ADCC_IDX_INT_ENABLE:    interrupt_enable_r <= wb[1:0];
        `ADCC_IDX_DEBUG_RUN:     run_while_debug_halted_r <= wb[0];
        `ADCC_IDX_TEMP_BYTE:     temporary_byte_r <= wb;
        `ADCC_IDX_WINLO_LO:      low_threshold_r[7:0] <= wb;
        `ADCC_IDX_WINLO_HI:      low_threshold_r[15:8] <= wb;
        `ADCC_IDX_WINHI_LO:      high_threshold_r[7:0] <= wb;
        `ADCC_IDX_WINHI_HI:      high_threshold_r[15:8] <= wb;
        default:                 temporary_byte_r <= temporary_byte_r;
      endcase
    end
  end

  // ========================================================================
  // converter clock divider: toggle every 2^code bus cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 8'h00;
      conv_clk  <= 1'b0;
    end else if (!may_run) begin
      div_cnt_r <= 8'h00;
      conv_clk  <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
      conv_clk  <= div_cnt_r[clock_divider];
    end
  end

  // ========================================================================
  // event input: three flops, an edge counts when stages two and three agree
  wire event_rise = event_sync_r[1] & event_sync_r[2] & ~event_level_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      event_sync_r  <= 3'h0;
      event_level_r <= 1'b0;
    end else begin
      event_sync_r <= {event_sync_r[1:0], start_event};
      if (event_sync_r[1] == event_sync_r[2])
        event_level_r <= event_sync_r[2];
    end
  end

  // ========================================================================
  // conversion sequencer
  wire cmd_write  = wr_en & (wr_idx == `ADCC_IDX_CONV_CMD);
  wire sw_start   = cmd_write & wb[0];
  wire sw_abort   = cmd_write & ~wb[0];
  wire ev_start   = event_start_enable_r & event_rise;
  wire trigger    = (sw_start | ev_start) & may_run;
  // drop two lsbs at 8-bit resolution, keep all ten otherwise
  wire [15:0] sample_val = res_select ?
                           {8'h00, conv_sample[SAMPLE_W-1:SAMPLE_W-8]} :
                           {{(16-SAMPLE_W){1'b0}}, conv_sample};
  wire [15:0] sum_val    = accum_r + sample_val;
  wire        last       = busy_r & conv_done & (samples_left_r == 7'h01);
  wire        win_low    = sum_val < low_threshold_r;
  wire        win_high   = sum_val > high_threshold_r;
  reg         win_hit;

  // window test on the final, full accumulated result only
  always @* begin
    case (window_compare_mode)
      `ADCC_WIN_BELOW:   win_hit = win_low;
      `ADCC_WIN_ABOVE:   win_hit = win_high;
      `ADCC_WIN_INSIDE:  win_hit = (sum_val > low_threshold_r) & (sum_val < high_threshold_r);
      `ADCC_WIN_OUTSIDE: win_hit = win_low | win_high;
      default:           win_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_r         <= 1'b0;
      waiting_r      <= 1'b0;
      conv_start     <= 1'b0;
      accum_r        <= 16'h0000;
      samples_left_r <= 7'h00;
      result_r       <= 16'h0000;
    end else begin
      conv_start <= 1'b0;
      if (sw_abort | ~enable) begin
        busy_r    <= 1'b0;
        waiting_r <= 1'b0;
      end else if (!may_run) begin
        busy_r <= busy_r;
      end else if (!busy_r & (trigger | waiting_r)) begin
        busy_r         <= 1'b1;
        waiting_r      <= 1'b0;
        conv_start     <= 1'b1;
        accum_r        <= 16'h0000;
        samples_left_r <= acc_samples(accumulation_count);
      end else if (busy_r & conv_done) begin
        accum_r <= sum_val;
        if (last) begin
          result_r  <= sum_val;
          busy_r    <= 1'b0;
          waiting_r <= free_running;
        end else begin
          samples_left_r <= samples_left_r - 7'h01;
          conv_start     <= 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // interrupt flags: set wins over a write-one clear in the same cycle
  wire [1:0] flag_set = {last & win_hit, last};
  wire [1:0] flag_clr = (wr_en & (wr_idx == `ADCC_IDX_INT_FLAGS)) ?
                        (wb[1:0] & `ADCC_MASK_FLAGS) : 2'h0;
  always @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_flags_r <= 2'h0;
      irq               <= 1'b0;
    end else begin
      interrupt_flags_r <= (interrupt_flags_r & ~flag_clr) | flag_set;
      irq <= |(((interrupt_flags_r & ~flag_clr) | flag_set) & interrupt_enable_r);
    end
  end

  // analog-side controls straight from flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      sample_capacitance_select <= 1'b0;
      reference_select          <= 2'h0;
      channel_select            <= 5'h00;
    end else begin
      sample_capacitance_select <= reference_clock_control_r[`ADCC_BIT_SAMPLE_CAPACITANCE_SELECT];
      reference_select          <= reference_clock_control_r[5:4];
      // channel change held off until the running conversion ends
      if (!busy_r)
        channel_select <= input_channel_select_r[4:0];
    end
  end

endmodule // adcc_top

// file: verification/adcc_core_model.sv
// adcc_core_model.sv - behavioural analog core: one sample per start pulse.
// assumes the start and done pulses run on aclk, as the top module expects.
`timescale 1ns/1ns
// ==========================================================================
// analog core model
module adcc_core_model (
  input  wire logic       aclk,
  input  wire logic       conv_start,
  input  wire logic [3:0] lat,
  input  wire logic [9:0] value,
  output logic            conv_done,
  output logic [9:0]      conv_sample
);
  int cnt;
  initial begin
    cnt = 0;
    conv_done = 1'b0;
    conv_sample = 10'h000;
  end
  // data toggles outside the done cycle so a stale sample is never read as good
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    conv_sample <= ~conv_sample;
    if (conv_start) cnt <= lat + 1;
    else if (cnt != 0) cnt <= cnt - 1;
    if (!conv_start && cnt == 1) begin
      conv_done <= 1'b1;
      conv_sample <= value;
    end
  end
endmodule // adcc_core_model

// file: verification/adcc_top_assertions.sv
// adcc_top_assertions.sv - bus handshake and sequencer checks.
// assumes it is bound to adcc_top and sees only its ports.
`timescale 1ns/1ns
// ==========================================================================
// checker
module adcc_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        conv_start,
  input wire        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read address taken, answer stalled by the master
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_stalled;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_reset_quiet: assert property ($rose(aresetn) |-> !conv_start && !irq && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read not answered on next edge");
  a_rvalid_hold: assert property (r_stalled |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 0)
    else $error("read upper bits or response not zero");
  a_write_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 && !s_axi_awready)
    else $error("write response not okay or address accepted");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
endmodule // adcc_chk

// file: verification/adcc_top_tb.sv
// adcc_top_tb.sv - self-checking bench: axi4-lite master, core model, checks.
// assumes adcc_top, adcc_core_model and adcc_chk are compiled before it.
`timescale 1ns/1ns
`include "adcc_regs.vh"
// ==========================================================================
// testbench top
module adcc_top_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
  logic        rry = 1'b0, sby = 1'b0, evt = 1'b0, awr, wr_r, bv, arr, rv, cst, cdn, cck, scap;
  logic        irq, ck_q = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdt;
  logic [1:0]  bresp, rresp, rsel;
  logic [4:0]  chs;
  logic [9:0]  csmp, val = 10'h000;
  logic [3:0]  lat = 4'h2;
  int          seed, err_count = 0, checked = 0, starts = 0, ck_cnt = 0, ck_per = 0;
  logic [9:0]  wsamp [3] = '{10'd50, 10'd300, 10'd600};
  adcc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .standby(sby),
    .start_event(evt), .conv_start(cst), .conv_done(cdn), .conv_sample(csmp), .conv_clk(cck),
    .sample_capacitance_select(scap), .reference_select(rsel), .channel_select(chs), .irq(irq));
  adcc_core_model i_core (.aclk(aclk), .conv_start(cst), .lat(lat), .value(val),
    .conv_done(cdn), .conv_sample(csmp));
  initial forever #25 aclk = ~aclk;
  // count start pulses and time the divided clock between rising samples
  always @(posedge aclk) begin
    ck_q <= cck;
    ck_cnt <= ck_cnt + 1;
    if (cck && !ck_q) begin
      ck_per <= ck_cnt + 1;
      ck_cnt <= 0;
    end
    if (cst) starts <= starts + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic lim();
    err_count++;
    tally_and_finish();
  endtask
  // byte address is four times the register index
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge aclk);
    {awa, wd, awv, wv, bry} <= {idx[5:0], 2'b00, 24'h0, d, 2'b11, 1'($random(seed))};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awr && awv) awv <= 1'b0;
      if (wr_r && wv) wv <= 1'b0;
      if (bv && bry) break;
      if (bv) bry <= 1'b1;
    end
    bry <= 1'b0;
    if (n == 50) lim();
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    int n;
    @(posedge aclk);
    {ara, arv, rry} <= {idx[5:0], 2'b00, 1'b1, 1'($random(seed))};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arr && arv) arv <= 1'b0;
      if (rv && rry) break;
      if (rv) rry <= 1'b1;
    end
    d = rdt[7:0];
    rry <= 1'b0;
    if (n == 50) lim();
  endtask
  // start a conversion, poll the command bit until it clears, fetch the result
  task automatic conv(output logic [15:0] r);
    logic [7:0] v;
    int n;
    wr(8'h08, 8'h01);
    for (n = 0; n < 400; n++) begin
      rd(8'h08, v);
      if (v === 8'h00) break;
    end
    if (n == 400) lim();
    rd(8'h10, r[7:0]);
    rd(8'h11, r[15:8]);
  endtask
  function automatic logic [15:0] exp_res(logic [2:0] c, logic rs, logic [9:0] s);
    logic [15:0] b = rs ? {8'h0, s[9:2]} : {6'h0, s};
    return (c == 3'h7) ? b : b << c;
  endfunction
  function automatic logic win(int m, logic [15:0] r, logic [15:0] lo, logic [15:0] hi);
    case (m)
      1: return r < lo;
      2: return r > hi;
      3: return r > lo && r < hi;
      default: return r < lo || r > hi;
    endcase
  endfunction
  // ========================================================================
  // main sequence
  logic [7:0]  v, d;
  logic [15:0] r;
  logic [7:0]  ix [12] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0a, 8'h07,
                           8'h03, 8'h0c, 8'h0d};
  logic [7:0]  mk [12] = '{8'h87, 8'h07, 8'h77, 8'h07, 8'h1f, 8'h1f, 8'h01, 8'h03, 8'h00,
                           8'hff, 8'h01, 8'hff};
  int          s0;
  initial begin
    seed = 68;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      rd(ix[i], v);
      chk("reset value", v, 8'h00);
      wr(ix[i], d);
      rd(ix[i], v);
      chk("masked readback", v, d & mk[i]);
      if (i == 2) chk("cap and ref", {scap, rsel}, d[6:4]);
      if (i == 5) chk("channel select", chs, d & 8'h1f);
      wr(ix[i], 8'h00);
    end
    $display("test registers done");
    wr(8'h00, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(8'h02, c[7:0]);
      repeat (600) @(posedge aclk);
      chk("divided clock period", ck_per, 2 << c);
    end
    wr(8'h02, 8'h00);
    $display("test divider done");
    for (int c = 0; c < 8; c++) begin
      val <= $random(seed);
      wr(8'h00, {5'h0, c[0], 2'b01});
      wr(8'h01, c[7:0]);
      wr(8'h0a, c[1] ? 8'h03 : 8'h02);
      conv(r);
      chk("result", r, exp_res(c[2:0], c[0], val));
      rd(8'h0b, v);
      chk("ready flag", v[0], 1'b1);
      chk("irq masked or raised", irq, c[1]);
      wr(8'h0b, 8'h01);
      rd(8'h0b, v);
      chk("irq after clear", irq, 1'b0);
    end
    $display("test accumulate done");
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h00);
    wr(8'h12, 8'h64);
    wr(8'h14, 8'hc8);
    wr(8'h15, 8'h01);
    rd(8'h15, v);
    chk("high threshold upper byte", v, 8'h01);
    for (int m = 1; m < 5; m++) for (int i = 0; i < 3; i++) begin
      val <= wsamp[i];
      wr(8'h04, m[7:0]);
      conv(r);
      rd(8'h0b, v);
      chk("window flag", v[1], win(m, r, 16'h0064, 16'h01c8));
      wr(8'h0b, 8'h03);
    end
    $display("test window done");
    lat <= 4'hf;
    wr(8'h01, 8'h06);
    wr(8'h08, 8'h01);
    rd(8'h08, v);
    chk("busy reads one", v, 8'h01);
    wr(8'h08, 8'h00);
    repeat (1200) @(posedge aclk);
    rd(8'h0b, v);
    chk("no flag after abort", v, 8'h00);
    {lat, sby} <= 5'h05;
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h81);
    conv(r);
    rd(8'h0b, v);
    chk("runs in standby", v[0], 1'b1);
    wr(8'h0b, 8'h03);
    wr(8'h00, 8'h00);
    s0 = starts;
    wr(8'h08, 8'h01);
    repeat (50) @(posedge aclk);
    chk("no start while disabled", starts - s0, 0);
    wr(8'h00, 8'h01);
    repeat (100) @(posedge aclk);
    chk("halted in standby", starts - s0, 0);
    sby <= 1'b0;
    conv(r);
    $display("test abort and standby done");
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h03);
    s0 = starts;
    repeat (100) @(posedge aclk);
    chk("free run waits for start", starts - s0, 0);
    wr(8'h08, 8'h01);
    repeat (300) @(posedge aclk);
    chk("free run restarts", starts - s0 > 3, 1'b1);
    wr(8'h00, 8'h01);
    wr(8'h09, 8'h01);
    wr(8'h0b, 8'h03);
    rd(8'h0b, v);
    chk("no flag before event", v, 8'h00);
    evt <= 1'b1;
    repeat (8) @(posedge aclk);
    evt <= 1'b0;
    repeat (60) @(posedge aclk);
    rd(8'h0b, v);
    chk("event started conversion", v[0], 1'b1);
    $display("test free run and event done");
    tally_and_finish();
  end
endmodule // adcc_top_tb

bind adcc_top adcc_chk i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_start(conv_start), .irq(irq));
